/* File: hdl/nvm_prog_port.sv */
// Parallel high-voltage programming port with flash, EEPROM, lock and low fuse
// How it works
// RULE1: Programmer powers up in order, reaching high voltage on reset within 64 ms.
// RULE2: Mode ends when supply drops or reset goes low; re-entry needs full sequence.
// RULE3: Programmer sets internal 8 MHz clock fuses, erasing first when locked.
// RULE4: Last command and address stay latched across many reads or writes.
// RULE5: Programmer reloads address high byte only when crossing a 256 window. The bench reloads it before every flash read.
// RULE6: Chip erase clears flash, EEPROM, then lock bits; fuses unchanged.
// RULE7: With EEPROM keep fuse programmed, erase spares the EEPROM.
// RULE8: Action 10, load strobe high pulse latches the command byte.
// RULE9: Erase command plus write strobe starts erase and drops ready.
// RULE10: Flash data gathers in a page buffer, programmed as a whole page.
// RULE11: Command 0x10 selects flash write.
// RULE12: Action 00 with byte select one low loads address low byte.
// RULE13: Action 01 with byte select one low loads data low byte.
// RULE14: Action 01 with byte select one high loads data high byte.
// RULE15: Low address bits pick the word, upper bits pick the page.
// RULE16: Action 00 with byte select one high loads two address high bits.
// RULE17: Write strobe with byte select one low programs the flash page, busy.
// RULE18: No-operation command resets the page write state.
// RULE19: Command 0x11, address and data loads, write strobe programs EEPROM page.
// RULE20: Command 0x02 reads flash word, low or high byte by byte select one.
// RULE21: Command 0x03 reads the addressed EEPROM byte.
// RULE22: Command 0x40, data low load, write strobe programs the low fuse.
// RULE23: Load strobe acts on action code; nothing changes without a strobe.
// RULE24: Ready is low while an operation runs, high when idle.
// RULE25: Data bus is driven only while output enable is low.
// RULE26: Write strobes during busy are ignored.
`timescale 1ns/100ps
module nvm_prog_port
  import nvm_port_pkg::*;
#(
  parameter int PROG_CYC  = PROG_CYCLES,   // Page and fuse program time in cycles
  parameter int ERASE_CYC = ERASE_CYCLES   // Chip erase time in cycles
) (
  input  wire logic       CLK_SYS,         // 40 MHz system clock
  input  wire logic       SYS_RST,         // Synchronous reset, active high
  input  wire logic       PROG_HV,         // Reset pin at programming voltage
  input  wire logic       SUPPLY_OK,       // Supply present
  input  wire logic       ACTION_SEL_HI,   // Action select bit 1
  input  wire logic       ACTION_SEL_LO,   // Action select bit 0
  input  wire logic       BYTE_SEL_ONE,    // Byte select one
  input  wire logic       BYTE_SEL_TWO,    // Byte select two
  input  wire logic       LOAD_STROBE_PIN, // Load strobe, rising edge acts
  input  wire logic       WRITE_STROBE_N,  // Write strobe, falling edge acts
  input  wire logic       OUT_ENABLE_N,    // Output enable, active low
  input  wire logic [7:0] DATA_IN,         // Data bus input side
  input  wire logic       EEPROM_KEEP_FUSE, // 1 while the EEPROM keep fuse is programmed
  input  wire logic [1:0] LOCK_STRAP,      // Stored lock bits, taken at mode entry
  output logic [7:0]      DATA_OUT,        // Data bus output side
  output logic            DATA_OE,         // Data bus output enable
  output logic            READY_BUSY_FLAG, // 1 ready, 0 busy
  output logic            PROG_MODE,       // Programming mode active
  output logic [7:0]      FUSE_LOW,        // Low fuse byte
  output logic [1:0]      LOCK_BITS        // Lock bits, 0 programmed
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DRAIN = 3'b001,
    ST_COPY  = 3'b010,
    ST_ERASE = 3'b011,
    ST_WAIT  = 3'b100
  } state_t;

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic              ld_d1_q;
  logic              wr_d1_q;
  logic              hv_s;
  logic              sup_s;
  logic              mode;
  logic [1:0]        act;
  logic              bs1;
  logic              bs2;
  logic              ld_s;
  logic              wr_s;
  logic              oe_n_s;
  logic [7:0]        din;
  logic [1:0]        lock_s;
  logic              keep_s;
  logic              load_go;
  logic              wr_fall;

  // Two flops on every pin; data settles well before the strobe does
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {PROG_HV, SUPPLY_OK, ACTION_SEL_HI, ACTION_SEL_LO, BYTE_SEL_ONE,
               BYTE_SEL_TWO, LOAD_STROBE_PIN, WRITE_STROBE_N, OUT_ENABLE_N,
               DATA_IN, EEPROM_KEEP_FUSE, LOCK_STRAP};
      s2_q <= s1_q;
    end
  end

  assign {hv_s, sup_s, act, bs1, bs2, ld_s, wr_s, oe_n_s, din, keep_s, lock_s} = s2_q;
  // Both pins combined only after the synchronisers, so no glitch reaches a flop
  assign mode = hv_s && sup_s;

  // Delayed copies of the synchronised strobes
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ld_d1_q <= 1'b0;
      wr_d1_q <= 1'b1;
    end else begin
      ld_d1_q <= ld_s;
      wr_d1_q <= wr_s;
    end
  end

  state_t            state_q;
  logic              busy;
  logic              mode_q;
  assign busy    = (state_q != ST_IDLE);
  assign load_go = mode && ld_s && !ld_d1_q && !busy;
  assign wr_fall = mode && !wr_s && wr_d1_q;

  // ****************************************
  // Command, address and data latches
  // ****************************************
  logic [7:0] cmd_q;
  logic [7:0] addr_lo_q;
  logic [1:0] addr_hi_q;
  logic [7:0] data_lo_q;
  logic [7:0] data_hi_q;

  // RULE23: act on action code
  // RULE4: latches hold between strobes
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !mode) begin
      cmd_q     <= CMD_NOP;
      addr_lo_q <= '0;
      addr_hi_q <= '0;
      data_lo_q <= '0;
      data_hi_q <= '0;
    end else if (load_go) begin
      case (act)
        // RULE12: address low byte
        // RULE16: two address high bits
        ACT_ADDR: begin
          if (bs1) addr_hi_q <= din[1:0];
          else     addr_lo_q <= din;
        end
        // RULE13: data low byte
        // RULE14: data high byte
        ACT_DATA: begin
          if (bs1) data_hi_q <= din;
          else     data_lo_q <= din;
        end
        // RULE8: command byte latch
        ACT_CMD: cmd_q <= din;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Data FIFO into the page buffers
  // ****************************************
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [FIFO_W-1:0] fifo_in_data;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic              is_flash_push;
  logic              is_ee_push;

  // Flash words complete on the high byte, EEPROM bytes on the low byte
  assign is_flash_push = load_go && (act == ACT_DATA) && bs1 && (cmd_q == CMD_WR_FLASH);
  assign is_ee_push    = load_go && (act == ACT_DATA) && !bs1 && (cmd_q == CMD_WR_EE);
  assign fifo_in_valid = is_flash_push || is_ee_push;
  assign fifo_in_data  = is_ee_push ? {1'b1, 2'b00, addr_lo_q[EE_IDX_W-1:0], 8'h00, din}
                                    : {1'b0, addr_lo_q[WORD_IDX_W-1:0], din, data_lo_q};
  // Draining stalls while a page is copied or erased; no load is taken while busy, so the FIFO cannot fill
  assign fifo_out_ready = (state_q == ST_IDLE) || (state_q == ST_DRAIN);

  nvm_word_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ****************************************
  // Page buffers
  // ****************************************
  logic [15:0] fbuf_q [PAGE_WORDS];
  logic [7:0]  ebuf_q [EE_PAGE];
  logic        nop_load;
  logic        copy_done;
  logic [WORD_IDX_W-1:0] idx_q;

  assign nop_load = load_go && (act == ACT_CMD) && (din == CMD_NOP);

  // RULE10: words gather before the page write
  // RULE18: no-operation clears write state
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || nop_load || copy_done) begin
      for (int i = 0; i < PAGE_WORDS; i++) fbuf_q[i] <= ERASED_WORD;
      for (int i = 0; i < EE_PAGE; i++) ebuf_q[i] <= ERASED_BYTE;
    end else if (fifo_out_valid && fifo_out_ready) begin
      if (fifo_out_data[20]) ebuf_q[fifo_out_data[17:16]] <= fifo_out_data[7:0];
      else                   fbuf_q[fifo_out_data[19:16]] <= fifo_out_data[15:0];
    end
  end

  // ****************************************
  // Operation sequencer and timer
  // ****************************************
  logic [FLASH_AW-1:0] sweep_q;
  logic [TIMER_W-1:0]  timer_q;
  logic                erase_op_q;
  logic                ee_op_q;
  logic                start;
  logic                go_erase;
  logic                go_page;
  logic                go_fuse;
  logic [TIMER_W-1:0]  target;
  logic [5:0]          page_sel;
  logic [EE_AW-3:0]    ee_page_sel;

  // RULE26: strobes during busy fall through
  assign go_erase = wr_fall && !busy && (cmd_q == CMD_ERASE);
  // RULE11: flash write selected by command
  assign go_page  = wr_fall && !busy && !bs1 &&
                    ((cmd_q == CMD_WR_FLASH) || (cmd_q == CMD_WR_EE));
  assign go_fuse  = wr_fall && !busy && !bs1 && !bs2 && (cmd_q == CMD_WR_FUSE);
  assign start    = go_erase || go_page || go_fuse;
  assign target   = erase_op_q ? TIMER_W'(ERASE_CYC) : TIMER_W'(PROG_CYC);
  assign copy_done = (state_q == ST_COPY) &&
                     (idx_q == (ee_op_q ? WORD_IDX_W'(EE_PAGE - 1) : WORD_IDX_W'(PAGE_WORDS - 1)));
  // RULE15: page from upper address bits
  assign page_sel    = {addr_hi_q, addr_lo_q[7:4]};
  assign ee_page_sel = addr_lo_q[EE_AW-1:EE_IDX_W];

  // RULE2: leaving the mode aborts any operation
  // RULE9: erase started by write strobe
  // RULE17: page program after the FIFO drains
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !mode) begin
      state_q    <= ST_IDLE;
      erase_op_q <= 1'b0;
      ee_op_q    <= 1'b0;
      idx_q      <= '0;
      sweep_q    <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          erase_op_q <= go_erase;
          ee_op_q    <= (cmd_q == CMD_WR_EE);
          idx_q      <= '0;
          sweep_q    <= '0;
          if (go_erase)     state_q <= ST_ERASE;
          else if (go_page) state_q <= ST_DRAIN;
          else if (go_fuse) state_q <= ST_WAIT;
        end
        ST_DRAIN: if (!fifo_out_valid) state_q <= ST_COPY;
        ST_COPY: begin
          idx_q <= idx_q + 1'b1;
          if (copy_done) state_q <= ST_WAIT;
        end
        ST_ERASE: begin
          sweep_q <= sweep_q + 1'b1;
          if (sweep_q == FLASH_AW'(FLASH_WORDS - 1)) state_q <= ST_WAIT;
        end
        ST_WAIT: if (timer_q >= target) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Timer runs from the accepted strobe so the whole operation meets the least time
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !mode || start) begin
      timer_q <= '0;
    end else if (busy && (timer_q != '1)) begin
      timer_q <= timer_q + 1'b1;
    end
  end

  // ****************************************
  // Nonvolatile arrays, lock and fuse
  // ****************************************
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0]  ee_mem [EE_BYTES];
  logic [7:0]  fuse_q;
  logic [1:0]  lock_q;
  logic        ee_erase_we;

  // RULE7: EEPROM kept when fuse programmed
  assign ee_erase_we = (state_q == ST_ERASE) && (sweep_q < FLASH_AW'(EE_BYTES)) && !keep_s;

  // Programming only pulls bits low, so rewriting needs an erase first
  always_ff @(posedge CLK_SYS) begin
    // RULE6: erase sweeps flash to all ones
    if (state_q == ST_ERASE) begin
      flash_mem[sweep_q] <= ERASED_WORD;
    end else if (state_q == ST_COPY && !ee_op_q) begin
      flash_mem[{page_sel, idx_q}] <= flash_mem[{page_sel, idx_q}] & fbuf_q[idx_q];
    end
  end

  // RULE19: EEPROM page write
  always_ff @(posedge CLK_SYS) begin
    if (ee_erase_we) begin
      ee_mem[sweep_q[EE_AW-1:0]] <= ERASED_BYTE;
    end else if (state_q == ST_COPY && ee_op_q) begin
      ee_mem[{ee_page_sel, idx_q[EE_IDX_W-1:0]}] <=
        ee_mem[{ee_page_sel, idx_q[EE_IDX_W-1:0]}] & ebuf_q[idx_q[EE_IDX_W-1:0]];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    mode_q <= SYS_RST ? 1'b0 : mode;
  end

  // Lock bits are taken at mode entry and released by system reset or at the end of the erase
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      lock_q <= LOCK_RST;
    end else if (mode && !mode_q) begin
      lock_q <= lock_s;
    end else if (state_q == ST_ERASE && sweep_q == FLASH_AW'(FLASH_WORDS - 1)) begin
      lock_q <= LOCK_RST;
    end
  end

  // RULE22: low fuse write, refused while lock bit one is programmed
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fuse_q <= FUSE_LOW_RST;
    end else if (go_fuse && lock_q[0]) begin
      fuse_q <= data_lo_q;
    end
  end

  // ****************************************
  // Read path and outputs
  // ****************************************
  logic [7:0]  dout_q;
  logic [15:0] rd_word;
  assign rd_word = flash_mem[{addr_hi_q, addr_lo_q}];

  // RULE20: flash word byte by byte select
  // RULE21: EEPROM byte read
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      dout_q <= '0;
    end else begin
      case (cmd_q)
        CMD_RD_FLASH: dout_q <= bs1 ? rd_word[15:8] : rd_word[7:0];
        CMD_RD_EE:    dout_q <= ee_mem[addr_lo_q[EE_AW-1:0]];
        CMD_RD_FUSE:  dout_q <= bs1 ? {6'h3f, lock_q} : fuse_q;
        default:      dout_q <= '0;
      endcase
    end
  end

  assign DATA_OUT  = dout_q;
  // RULE25: drive only with output enable low
  assign DATA_OE   = mode && !oe_n_s;
  // RULE24: ready while idle with FIFO room
  assign READY_BUSY_FLAG = !busy && fifo_in_ready;
  assign PROG_MODE = mode;
  assign FUSE_LOW  = fuse_q;
  assign LOCK_BITS = lock_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  a_cmd_latch: assert property (load_go && act == ACT_CMD |=> cmd_q == $past(din)) // RULE8
    else $error("Command byte not latched");
  a_addr_lo_load: assert property (load_go && act == ACT_ADDR && !bs1 |=> addr_lo_q == $past(din)) // RULE12
    else $error("Address low byte not latched");
  a_addr_hi_load: assert property (load_go && act == ACT_ADDR && bs1 |=> addr_hi_q == $past(din[1:0])) // RULE16
    else $error("Address high bits not latched");
  a_data_lo_load: assert property (load_go && act == ACT_DATA && !bs1 |=> data_lo_q == $past(din)) // RULE13
    else $error("Data low byte not latched");
  a_data_hi_load: assert property (load_go && act == ACT_DATA && bs1 |=> data_hi_q == $past(din)) // RULE14
    else $error("Data high byte not latched");
  a_cmd_held_still: assert property (mode && !load_go ##1 mode |-> $stable(cmd_q)) // RULE4
    else $error("Command changed without a strobe");
  a_erase_busy: assert property (go_erase |=> !READY_BUSY_FLAG [*8]) // RULE9
    else $error("Erase did not drop ready");
  a_page_start: assert property (go_page && cmd_q == CMD_WR_FLASH |=> state_q == ST_DRAIN) // RULE17
    else $error("Page program not started");
  a_busy_ready_low: assert property (busy |-> !READY_BUSY_FLAG) // RULE24
    else $error("Ready high while busy");
  a_bus_drive_oe: assert property (DATA_OE |-> $past(!OUT_ENABLE_N, 2) && mode) // RULE25
    else $error("Bus driven without output enable");
  a_lock_after_erase: assert property (state_q == ST_ERASE && sweep_q == FLASH_AW'(FLASH_WORDS - 1)
                                       |=> lock_q == LOCK_RST && state_q == ST_WAIT) // RULE6
    else $error("Lock bits not released after erase");
  a_ee_keep_erase: assert property (ee_erase_we |-> !keep_s && state_q == ST_ERASE) // RULE7
    else $error("EEPROM erased while keep fuse programmed");
  a_nop_clears_buf: assert property (nop_load |=> fbuf_q[0] == ERASED_WORD) // RULE18
    else $error("No-operation left the page buffer loaded");
  a_busy_wr_ignored: assert property (disable iff (SYS_RST || !mode)
                                      wr_fall && busy |=> timer_q != '0) // RULE26
    else $error("Write strobe restarted a busy operation");

  c_erase_done: cover property (state_q == ST_ERASE ##1 state_q == ST_WAIT);
  c_flash_page: cover property (go_page && cmd_q == CMD_WR_FLASH);
  c_ee_page: cover property (go_page && cmd_q == CMD_WR_EE);
  c_fuse_write: cover property (go_fuse && lock_q[0]);
endmodule

/* File: hdl/nvm_port_pkg.sv */
// Constants shared by the parallel programming port and its data FIFO
package nvm_port_pkg;
  // Clock and operation times
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_NS  = 3_700_000;  // 3.7 ms least page or fuse program time
  localparam int ERASE_TIME_NS = 7_500_000;  // 7.5 ms least chip erase time
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 20;
  localparam int SYNC_W        = 20;

  // Command bytes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  // Action select codes on a load strobe
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;

  // Memory geometry
  localparam int FLASH_WORDS = 1024;
  localparam int FLASH_AW    = 10;
  localparam int PAGE_WORDS  = 16;
  localparam int WORD_IDX_W  = 4;
  localparam int EE_BYTES    = 128;
  localparam int EE_AW       = 7;
  localparam int EE_PAGE     = 4;
  localparam int EE_IDX_W    = 2;

  // Reset and erased values
  localparam logic [7:0]  FUSE_LOW_RST = 8'he1;
  localparam logic [1:0]  LOCK_RST     = 2'h3;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;

  // FIFO entry: {eeprom, word index, data word}
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 21;
endpackage

/* File: hdl/nvm_word_fifo.sv */
// Small synchronous FIFO carrying loaded data words to the page buffer
`timescale 1ns/100ps
module nvm_word_fifo #(
  parameter int W     = 21,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst,       // Synchronous reset, active high
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Room for one more word
  input  wire logic [W-1:0] in_data,   // Word to store
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Reader takes the word
  output logic [W-1:0]      out_data   // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Full and empty straight from the fill count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage, no reset needed for the data itself
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: tb/nvm_programmer.sv */
// Behavioural parallel programmer that drives the port's pins
`timescale 1ns/100ps
module nvm_programmer (
  input  wire logic       clk,  // System clock
  input  wire logic [7:0] dout, // Device read data
  input  wire logic       doe,  // Device drives the bus
  output logic            hv,   // Reset at programming voltage
  output logic            sup,  // Supply present
  output logic [1:0]      act,  // Action select {hi,lo}
  output logic            bs1,  // Byte select one
  output logic            bs2,  // Byte select two
  output logic            ld,   // Load strobe
  output logic            wr_n, // Write strobe
  output logic            oe_n, // Output enable
  output logic [7:0]      drv   // Value put on the bus
);
  // entry pins, reset and supply all start at zero
  initial begin
    {hv, sup, act, bs1, bs2, ld, wr_n, drv} = '0;
    oe_n = 1'b1;
  end
  // Pins change a fixed delay after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // supply, 60 us, reset at supply, 20 us, high voltage, 10 us
  task automatic enter();
    sup = 1'b1;
    tick(2400);
    tick(800);
    hv = 1'b1;
    tick(400);
    wr_n = 1'b1;
    act = 2'b11;
    tick(5);
  endtask
  // leaving the mode by pulling reset down
  task automatic leave();
    hv = 1'b0;
    tick(5);
  endtask
  // codes held well around the load pulse
  task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
    act = a;
    bs1 = b;
    drv = d;
    tick(5);
    ld = 1'b1;
    tick(5);
    ld = 1'b0;
    tick(5);
  endtask
  // low pulse on the write strobe with byte select two low and byte select one from b
  task automatic write(input logic b);
    bs1 = b;
    bs2 = 1'b0;
    tick(5);
    wr_n = 1'b0;
    tick(5);
    wr_n = 1'b1;
    tick(2);
  endtask
  // Output enable low long enough for the synchronisers to settle
  task automatic read(input logic b, output logic [7:0] v, output logic o);
    bs1 = b;
    oe_n = 1'b0;
    tick(6);
    v = dout;
    o = doe;
    oe_n = 1'b1;
    tick(4);
  endtask
endmodule

/* File: tb/nvm_prog_port_tb.sv */
// Self-checking bench for the parallel programming port
`timescale 1ns/100ps
module nvm_prog_port_tb;
  import nvm_port_pkg::*;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       keep = 1'b0;
  logic [1:0] strap = 2'b00;
  logic       hv, sup, bs1, bs2, ld, wr_n, oe_n, oe, rdy, mode, got_oe;
  logic [1:0] act, lock;
  logic [7:0] drv, dout, din, fuse, lo_b, hi_b;
  logic [9:0] base;
  logic [6:0] eb;
  logic [15:0] rnd = 16'h7778;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         flash [1024];
  int         ee [128];
  always #12.5 clk_sys = ~clk_sys;
  // Wire level: device while enabled, otherwise the programmer's value, inverted while output enable is low
  assign din = oe ? dout : (oe_n ? drv : ~drv);
  nvm_programmer prog (.clk(clk_sys), .dout(dout), .doe(oe), .hv(hv), .sup(sup), .act(act),
    .bs1(bs1), .bs2(bs2), .ld(ld), .wr_n(wr_n), .oe_n(oe_n), .drv(drv));
  // Short program and erase times keep the run brief
  nvm_prog_port #(.PROG_CYC(40), .ERASE_CYC(1100)) DUT (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
    .PROG_HV(hv), .SUPPLY_OK(sup), .ACTION_SEL_HI(act[1]), .ACTION_SEL_LO(act[0]),
    .BYTE_SEL_ONE(bs1), .BYTE_SEL_TWO(bs2), .LOAD_STROBE_PIN(ld), .WRITE_STROBE_N(wr_n),
    .OUT_ENABLE_N(oe_n), .DATA_IN(din), .EEPROM_KEEP_FUSE(keep), .LOCK_STRAP(strap),
    .DATA_OUT(dout), .DATA_OE(oe), .READY_BUSY_FLAG(rdy), .PROG_MODE(mode), .FUSE_LOW(fuse),
    .LOCK_BITS(lock));
  // ****************************************
  // Checking helpers and operations
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] next_rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for ready; running out ends the run
  task automatic program_op(input int bound);
    prog.write(1'b0);
    chk("busy", 16'h0000, {15'h0, rdy});
    for (int i = 0; i < bound && rdy !== 1'b1; i++) prog.tick(1);
    chk("ready", 16'h0001, {15'h0, rdy});
    if (rdy !== 1'b1) give_verdict();
  endtask
  task automatic cmd(input logic [7:0] c);
    prog.load(2'b10, 1'b0, c);
  endtask
  task automatic read_flash(input logic [9:0] a);
    cmd(CMD_RD_FLASH);
    prog.load(2'b00, 1'b1, {6'h0, a[9:8]});
    prog.load(2'b00, 1'b0, a[7:0]);
    prog.load(2'b11, 1'b0, ~a[7:0]);
    prog.read(1'b0, lo_b, got_oe);
    prog.read(1'b1, hi_b, got_oe);
    chk("flash word", 16'(flash[a]), {hi_b, lo_b});
  endtask
  task automatic read_ee(input logic [6:0] a);
    cmd(CMD_RD_EE);
    prog.load(2'b00, 1'b0, {1'b0, a});
    prog.read(1'b0, lo_b, got_oe);
    chk("eeprom byte", 16'(ee[a]), {8'h0, lo_b});
    chk("bus enable", 16'h0001, {15'h0, got_oe});
  endtask
  task automatic erase(input logic k);
    keep = k;
    cmd(CMD_ERASE);
    program_op(3000);
    foreach (flash[i]) flash[i] = 16'hffff;
    if (!k) foreach (ee[i]) ee[i] = 8'hff;
    chk("lock bits", 16'h0003, {14'h0, lock});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    #2 sys_rst = 1'b0;
    chk("reset state", {4'h0, 2'b10, FUSE_LOW_RST, LOCK_RST}, {4'h0, rdy, mode, fuse, lock});
    prog.enter();
    chk("entry", 16'h0004, {13'h0, mode, lock});
    cmd(CMD_WR_FUSE);
    prog.load(2'b01, 1'b0, 8'h00);
    program_op(500);
    chk("locked fuse", {8'h0, FUSE_LOW_RST}, {8'h0, fuse});
    erase(1'b0);
    $display("test entry and erase done");
    rnd = next_rnd(rnd);
    base = {rnd[9:4], 4'h0};
    cmd(CMD_WR_FLASH);
    for (int k = 0; k < 4; k++) begin
      rnd = next_rnd(rnd);
      prog.load(2'b00, 1'b0, {base[7:4], 4'(k * 5)});
      prog.load(2'b01, 1'b0, rnd[7:0]);
      prog.load(2'b01, 1'b1, rnd[15:8]);
      flash[base + 10'(k * 5)] &= int'(rnd);
    end
    prog.load(2'b00, 1'b1, {6'h0, base[9:8]});
    program_op(2000);
    for (int k = 0; k < 4; k++) read_flash(base + 10'(k * 5));
    read_flash(base + 10'd1);
    $display("test flash page done");
    eb = {rnd[6:2], 2'b00};
    cmd(CMD_WR_EE);
    for (int k = 0; k < 4; k++) begin
      rnd = next_rnd(rnd);
      prog.load(2'b00, 1'b0, {1'b0, eb[6:2], 2'(k)});
      prog.load(2'b01, 1'b0, rnd[7:0]);
      ee[eb + 7'(k)] &= int'(rnd[7:0]);
    end
    program_op(2000);
    for (int k = 0; k < 4; k++) read_ee(eb + 7'(k));
    $display("test eeprom page done");
    rnd = next_rnd(rnd);
    cmd(CMD_WR_FUSE);
    prog.load(2'b01, 1'b0, {rnd[7:6], 6'h24});
    program_op(500);
    chk("low fuse", {8'h0, rnd[7:6], 6'h24}, {8'h0, fuse});
    cmd(CMD_RD_FUSE);
    prog.read(1'b0, lo_b, got_oe);
    prog.read(1'b1, hi_b, got_oe);
    chk("fuse read", {rnd[7:6], 6'h24, 8'hff}, {lo_b, hi_b});
    cmd(CMD_NOP);
    erase(1'b1);
    for (int k = 0; k < 4; k++) read_ee(eb + 7'(k));
    read_flash(base);
    chk("fuse kept", {8'h0, rnd[7:6], 6'h24}, {8'h0, fuse});
    $display("test keep erase done");
    prog.leave();
    prog.read(1'b0, lo_b, got_oe);
    chk("exit", 16'h0000, {14'h0, mode, got_oe});
    $display("test exit done");
    give_verdict();
  end
  // Watchdog on the whole run
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    $display("[ERR] run length expected done seen running");
    give_verdict();
  end
endmodule
